// ===== hdl/ms_tick.sv
// Free-running divider producing a one-cycle millisecond tick.
// Assumes the synchronised reset of the top module.
`timescale 1ns/1ns
`default_nettype none
module ms_tick #(
  parameter int unsigned CYCLES = 20000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output var  logic tick
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // Count clock cycles and pulse at the end of each period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= (count == LAST);
      if (count == LAST) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : ms_tick
`default_nettype wire

// ===== hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes one clock; output changes only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ===== hdl/safety_relay_params.svh
// Constants for the safety relay and its expansion unit.
// Assumes a 20 MHz system clock; the reset and jog-rest times below are counted in millisecond ticks, the settle count in clock cycles.
//
// Notes on behaviour
// - Setting 1: either input or link requests on; monitored manual reset required.
// - Setting 6: both inputs or link request on; reset is automatic.
// - OR logic works with one device; open second input raises no fault.
// - Turn on only while contactor feedback shows both contactors de-energised.
// - Auxiliary status output is on whenever the safety outputs are off.
// - Expansion without delay follows the link signal directly.
// - Expansion passes reset loop through its feedback terminal; relay reads it.
// - Off-delay: expansion stays on for the delay after link drops.
// - Retrigger: link returning during off-delay restarts timer, no output gap.
// - On-delay: expansion turns on only after delay since link went on.
// - Jog: outputs on only while link and jog held; release turns off.
// - Jog on-time limited to configured maximum even if jog is held.
// - Automatic reset turns on as soon as inputs close, contactors off.
// - Manual reset pulse must last 0.25 to 3 seconds before release.
// - After each jog, outputs stay off 500 ms before next jog.
`ifndef SAFETY_RELAY_PARAMS_SVH
`define SAFETY_RELAY_PARAMS_SVH

// ==========================================
// Timing
`define CLOCK_PERIOD_NS   50
`define TICK_PERIOD_NS    1000000
`define TICK_CYCLES       (`TICK_PERIOD_NS / `CLOCK_PERIOD_NS)
`define RESET_MIN_MS      12'h0fa
`define RESET_MAX_MS      12'hbb8
`define JOG_REST_MS       17'h001f4
`define CFG_SETTLE        3'h4

// ==========================================
// Widths and configuration limits
`define TIMER_W           17
`define PRESS_W           12
`define SETTING_W         4
`define SETTING_MIN       4'h1
`define SETTING_MAX       4'h8
`define SETTING_AUTO_MIN  4'h5

`endif

// ===== hdl/safety_relay_pkg.sv
// Types shared by the safety relay design.
// Assumes safety_relay_params.svh is available on the include path.
package safety_relay_pkg;

  // ==========================================
  // Expansion timing modes
  typedef enum logic [1:0] {
    MODE_IMMEDIATE = 2'h0,
    MODE_OFF_DELAY = 2'h1,
    MODE_ON_DELAY  = 2'h2,
    MODE_JOG       = 2'h3
  } exp_mode_e;

  // ==========================================
  // Relay states
  typedef enum logic [3:0] {
    R_OFF   = 4'h1,
    R_PRESS = 4'h2,
    R_STUCK = 4'h4,
    R_ON    = 4'h8
  } relay_state_e;

  // ==========================================
  // Expansion states
  typedef enum logic [6:0] {
    E_OFF  = 7'h01,
    E_ON   = 7'h02,
    E_HOLD = 7'h04,
    E_PEND = 7'h08,
    E_JOG  = 7'h10,
    E_REST = 7'h20,
    E_WAIT = 7'h40
  } exp_state_e;

endpackage : safety_relay_pkg

// ===== hdl/safety_relay_top.sv
// Safety relay logic with a delay/jog expansion unit on the single-wire link.
// Assumes all pin inputs are asynchronous; straps are stable at power-up.
`include "safety_relay_params.svh"
`timescale 1ns/1ns
`default_nettype none
module safety_relay_top #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  // Relay pins
  input  wire logic                            safety_input_a,
  input  wire logic                            safety_input_b,
  input  wire logic                            relay_link_in,
  input  wire logic                            feedback_reset_loop,
  output var  logic                            contactor_one,
  output var  logic                            contactor_two,
  output var  logic                            link_out_terminal,
  output var  logic                            aux_off_status_out,
  output var  logic                            config_fault,
  // Expansion pins
  input  wire logic                            link_in_terminal,
  input  wire logic                            jog_retrigger_input,
  input  wire logic                            retrigger_strap_terminal,
  input  wire logic                            exp_contact_loop_in,
  output var  logic                            exp_output_on,
  output var  logic                            expansion_feedback_out,
  // Power-up straps
  input  wire logic [`SETTING_W-1:0]           logic_setting,
  input  wire safety_relay_pkg::exp_mode_e     exp_mode,
  input  wire logic [`TIMER_W-1:0]             delay_setting_ms
);
  import safety_relay_pkg::*;

  // ==========================================
  // Reset release and millisecond tick
  logic rst_meta;
  logic rst_sync_n;
  logic tick;

  // Release reset through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ms_tick #(.CYCLES(TICK_CYCLES)) tick_gen (
    .clock (clock),
    .rst_n (rst_sync_n),
    .tick  (tick)
  );

  // ==========================================
  // Pin synchronisers
  localparam int PIN_W = 8;
  localparam int CFG_W = `SETTING_W + 2 + `TIMER_W + 1;

  logic [PIN_W-1:0] pins;
  logic [CFG_W-1:0] cfg_pins;
  logic [CFG_W-1:0] cfg_level;
  logic             in_a;
  logic             in_b;
  logic             rly_link;
  logic             loop;
  logic             exp_link;
  logic             jog;
  logic             exp_loop;
  logic             exp_loop_unused;

  assign pins = {1'b0, exp_contact_loop_in, jog_retrigger_input, link_in_terminal,
                 feedback_reset_loop, relay_link_in, safety_input_b, safety_input_a};
  assign cfg_pins = {retrigger_strap_terminal, exp_mode, delay_setting_ms, logic_setting};

  pin_sync #(.WIDTH(PIN_W)) pin_filter (
    .clock (clock),
    .rst_n (rst_sync_n),
    .pin   (pins),
    .level ({exp_loop_unused, exp_loop, jog, exp_link, loop, rly_link, in_b, in_a})
  );

  pin_sync #(.WIDTH(CFG_W)) cfg_filter (
    .clock (clock),
    .rst_n (rst_sync_n),
    .pin   (cfg_pins),
    .level (cfg_level)
  );

  // ==========================================
  // Power-up configuration capture
  logic [2:0]            settle;
  logic                  cfg_ready;
  logic [`SETTING_W-1:0] setting;
  exp_mode_e             mode;
  logic [`TIMER_W-1:0]   delay_ms;
  logic                  retrig;
  logic                  cfg_ok;
  logic                  or_logic;
  logic                  auto_reset;

  // Take the straps once after the filters settle, never again
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      settle    <= 3'h0;
      cfg_ready <= 1'b0;
      setting   <= '0;
      mode      <= MODE_IMMEDIATE;
      delay_ms  <= '0;
      retrig    <= 1'b0;
    end else if (!cfg_ready) begin
      settle <= settle + 1'b1;
      if (settle == `CFG_SETTLE) begin
        cfg_ready <= 1'b1;
        setting   <= cfg_level[`SETTING_W-1:0];
        delay_ms  <= cfg_level[`SETTING_W +: `TIMER_W];
        mode      <= exp_mode_e'(cfg_level[`SETTING_W+`TIMER_W +: 2]);
        retrig    <= cfg_level[CFG_W-1];
      end
    end
  end

  // Decode logic setting: odd is OR, even is AND; upper half resets automatically
  assign cfg_ok     = (setting >= `SETTING_MIN) && (setting <= `SETTING_MAX);
  assign or_logic   = setting[0];
  assign auto_reset = (setting >= `SETTING_AUTO_MIN);

  // Saturating millisecond counter step
  function automatic logic [`TIMER_W-1:0] step_ms(input logic [`TIMER_W-1:0] v,
                                                  input logic t);
    step_ms = (t && (v != '1)) ? v + 1'b1 : v;
  endfunction : step_ms

  // ==========================================
  // Relay: request, reset and output control
  relay_state_e          rly_state;
  relay_state_e          next_rly_state;
  logic                  request;
  logic                  loop_prev;
  logic [`TIMER_W-1:0]   press_ms;
  logic                  press_ok;

  // Combine the inputs under the chosen logic; OR needs only one device
  always_comb begin
    if (or_logic) begin
      request = in_a | in_b | rly_link;
    end else begin
      request = (in_a & in_b) | rly_link;
    end
  end

  assign press_ok = (press_ms >= `TIMER_W'(`RESET_MIN_MS)) &&
                    (press_ms <= `TIMER_W'(`RESET_MAX_MS));

  // Relay next state
  always_comb begin
    next_rly_state = rly_state;
    case (rly_state)
      R_OFF: begin
        if (cfg_ready && cfg_ok && request) begin
          if (auto_reset) begin
            if (loop) begin
              next_rly_state = R_ON;
            end
          end else if (loop && !loop_prev) begin
            next_rly_state = R_PRESS;
          end
        end
      end
      R_PRESS: begin
        if (!loop) begin
          if (press_ok && request) begin
            next_rly_state = R_ON;
          end else begin
            next_rly_state = R_OFF;
          end
        end else if (press_ms > `TIMER_W'(`RESET_MAX_MS)) begin
          next_rly_state = R_STUCK;
        end
      end
      R_STUCK: begin
        if (!loop) begin
          next_rly_state = R_OFF;
        end
      end
      R_ON: begin
        if (!request) begin
          next_rly_state = R_OFF;
        end
      end
      default: begin
        next_rly_state = R_OFF;
      end
    endcase
  end

  // Relay state register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rly_state <= R_OFF;
      loop_prev <= 1'b1;
    end else begin
      rly_state <= next_rly_state;
      loop_prev <= loop;
    end
  end

  // Reset pulse width timer, cleared on entry to the press state
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      press_ms <= '0;
    end else if (rly_state != R_PRESS) begin
      press_ms <= '0;
    end else begin
      press_ms <= step_ms(press_ms, tick);
    end
  end

  // Relay outputs; auxiliary status shows the off state
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      contactor_one      <= 1'b0;
      contactor_two      <= 1'b0;
      link_out_terminal  <= 1'b0;
      aux_off_status_out <= 1'b1;
      config_fault       <= 1'b0;
    end else begin
      contactor_one      <= (next_rly_state == R_ON);
      contactor_two      <= (next_rly_state == R_ON);
      link_out_terminal  <= (next_rly_state == R_ON);
      aux_off_status_out <= (next_rly_state != R_ON);
      config_fault       <= cfg_ready && !cfg_ok;
    end
  end

  // ==========================================
  // Expansion unit: delay and jog control
  exp_state_e          exp_state;
  exp_state_e          next_exp_state;
  logic [`TIMER_W-1:0] exp_ms;
  logic                delay_done;
  logic                rest_done;
  logic                jog_req;

  assign delay_done = (exp_ms >= delay_ms);
  assign rest_done  = (exp_ms >= `JOG_REST_MS);
  assign jog_req    = exp_link & jog;

  // Expansion next state
  always_comb begin
    next_exp_state = exp_state;
    case (exp_state)
      E_OFF: begin
        if (cfg_ready) begin
          case (mode)
            MODE_ON_DELAY: begin
              if (exp_link) begin
                next_exp_state = E_PEND;
              end
            end
            MODE_JOG: begin
              if (jog_req) begin
                next_exp_state = E_JOG;
              end
            end
            default: begin
              if (exp_link) begin
                next_exp_state = E_ON;
              end
            end
          endcase
        end
      end
      E_ON: begin
        if (!exp_link) begin
          if (mode == MODE_OFF_DELAY) begin
            next_exp_state = E_HOLD;
          end else begin
            next_exp_state = E_OFF;
          end
        end
      end
      E_HOLD: begin
        if (exp_link && retrig) begin
          next_exp_state = E_ON;
        end else if (delay_done) begin
          next_exp_state = E_OFF;
        end
      end
      E_PEND: begin
        if (!exp_link) begin
          next_exp_state = E_OFF;
        end else if (delay_done) begin
          next_exp_state = E_ON;
        end
      end
      E_JOG: begin
        if (!jog_req || delay_done) begin
          next_exp_state = E_REST;
        end
      end
      E_REST: begin
        if (rest_done) begin
          next_exp_state = E_WAIT;
        end
      end
      E_WAIT: begin
        if (!jog_req) begin
          next_exp_state = E_OFF;
        end
      end
      default: begin
        next_exp_state = E_OFF;
      end
    endcase
  end

  // Expansion state register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      exp_state <= E_OFF;
    end else begin
      exp_state <= next_exp_state;
    end
  end

  // Expansion timer restarts on every state change
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      exp_ms <= '0;
    end else if (next_exp_state != exp_state) begin
      exp_ms <= '0;
    end else begin
      exp_ms <= step_ms(exp_ms, tick);
    end
  end

  // Expansion outputs; feedback passes the loop only while outputs are off
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      exp_output_on          <= 1'b0;
      expansion_feedback_out <= 1'b0;
    end else begin
      exp_output_on <= (next_exp_state == E_ON) ||
                       (next_exp_state == E_HOLD) ||
                       (next_exp_state == E_JOG);
      expansion_feedback_out <= exp_loop &&
                                (next_exp_state != E_ON) &&
                                (next_exp_state != E_HOLD) &&
                                (next_exp_state != E_JOG);
    end
  end

endmodule : safety_relay_top
`default_nettype wire

// ===== tb/relay_plant.sv
// Contactors, reset button and feedback wiring around the relay and expansion.
// Assumes coils are the registered outputs of the top module.
`timescale 1ns/1ns
`default_nettype none
module relay_plant (
  input  wire logic clock,
  input  wire logic contactor_one,
  input  wire logic contactor_two,
  input  wire logic exp_output_on,
  input  wire logic button,
  input  wire logic weld,
  input  wire logic expansion_feedback_out,
  output var  logic exp_contact_loop_in,
  output var  logic feedback_reset_loop
);
  logic energised;

  // Armatures follow the coils a clock late; a weld keeps them pulled in
  always_ff @(posedge clock) begin
    energised <= contactor_one | contactor_two | exp_output_on | weld;
  end

  // Break contacts in series with the reset button open while any armature is in
  assign exp_contact_loop_in = button & ~energised;
  // Relay reset is sourced from the expansion feedback terminal
  assign feedback_reset_loop = expansion_feedback_out;
endmodule : relay_plant
`default_nettype wire

// ===== tb/safety_relay_props.sv
// Port-level assertions for the safety relay top module.
// Assumes it is bound into safety_relay_top and that the delay strap holds 10 ms.
`timescale 1ns/1ns
`default_nettype none
module safety_relay_props #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic                        safety_input_a,
  input wire logic                        safety_input_b,
  input wire logic                        relay_link_in,
  input wire logic                        feedback_reset_loop,
  input wire logic                        contactor_one,
  input wire logic                        aux_off_status_out,
  input wire logic                        link_in_terminal,
  input wire logic                        jog_retrigger_input,
  input wire logic                        exp_output_on,
  input wire logic [3:0]                  logic_setting,
  input wire safety_relay_pkg::exp_mode_e exp_mode,
  input wire logic [16:0]                 delay_setting_ms
);
  import safety_relay_pkg::*;

  // ==========================================
  // Helper logic
  logic        req;
  logic [8:0]  on_run;
  logic [15:0] off_run;

  // Odd settings OR the two inputs, even settings AND them
  assign req = logic_setting[0] ? (safety_input_a | safety_input_b | relay_link_in)
                                : ((safety_input_a & safety_input_b) | relay_link_in);

  // Length of the current jog and of the gap since the last one; gap saturates
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_run  <= 9'h000;
      off_run <= 16'hffff;
    end else begin
      on_run  <= (exp_output_on && exp_mode == MODE_JOG) ? on_run + 9'h001 : 9'h000;
      off_run <= exp_output_on ? 16'h0000 : off_run + {15'h0000, ~&off_run};
    end
  end

  // ==========================================
  // Assertions
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_aux_mirror: assert property (aux_off_status_out == !contactor_one)
    else $error("aux status disagrees with contactor state");
  chk_on_request: assert property ($rose(contactor_one) |-> $past(req, 4))
    else $error("relay turned on without a request");
  chk_auto_loop: assert property (
    $rose(contactor_one) && logic_setting >= 4'h5 |-> $past(feedback_reset_loop, 4))
    else $error("automatic start with feedback loop open");
  chk_drop_off: assert property (contactor_one && !req |-> ##[1:6] !contactor_one)
    else $error("relay stayed on after request dropped");
  chk_exp_follow: assert property (
    exp_mode == MODE_IMMEDIATE && link_in_terminal != exp_output_on |-> ##[1:6] link_in_terminal == exp_output_on)
    else $error("expansion did not follow link");
  chk_offdelay_span: assert property (
    $fell(exp_output_on) && exp_mode == MODE_OFF_DELAY |-> !$past(link_in_terminal, 150))
    else $error("off-delay output dropped too early");
  chk_ondelay_wait: assert property (
    $rose(exp_output_on) && exp_mode == MODE_ON_DELAY |-> $past(link_in_terminal, 150))
    else $error("on-delay output came on too early");
  chk_jog_release: assert property (
    exp_mode == MODE_JOG && exp_output_on && !(jog_retrigger_input && link_in_terminal) |-> ##[1:6] !exp_output_on)
    else $error("jog output stayed on after release");
  chk_jog_limit: assert property (on_run <= delay_setting_ms * TICK_CYCLES + 10)
    else $error("jog ran past its maximum time");
  chk_jog_rest: assert property (
    $rose(exp_output_on) && exp_mode == MODE_JOG |-> off_run >= 499 * TICK_CYCLES)
    else $error("jog restarted inside the rest time");
endmodule : safety_relay_props
`default_nettype wire

// ===== tb/test_safety_relay_logic_delay_expansion.sv
// Self-checking bench for the relay and expansion unit.
// Assumes the plant model stands in for contactors, button and feedback wiring.
`timescale 1ns/1ns
`default_nettype none
module test_safety_relay_logic_delay_expansion;
  import safety_relay_pkg::*;

  // ==========================================
  // Signals
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [6:0] pins  = 7'h20;  // Weld, button, jog, exp link, relay link, b, a
  logic [3:0] logic_setting = 4'h6;
  exp_mode_e  exp_mode = MODE_IMMEDIATE;
  logic       retrigger_strap_terminal = 1'b0;
  logic       contactor_one, contactor_two, link_out_terminal, aux_off_status_out, config_fault;
  logic       exp_output_on, expansion_feedback_out, exp_contact_loop_in, feedback_reset_loop;
  logic [5:0] outs;
  int         n_fail = 0;
  int         checks = 0;

  // Observed outputs packed for comparison
  assign outs = {config_fault, contactor_one, contactor_two, link_out_terminal, aux_off_status_out, exp_output_on};

  // 20 MHz clock
  initial begin
    forever #25 clock = ~clock;
  end

  // ==========================================
  // Instances
  safety_relay_top #(.TICK_CYCLES(20)) dut_u (
    .clock, .rst_n, .safety_input_a(pins[0]), .safety_input_b(pins[1]), .relay_link_in(pins[2]),
    .feedback_reset_loop, .contactor_one, .contactor_two, .link_out_terminal, .aux_off_status_out,
    .config_fault, .link_in_terminal(pins[3]), .jog_retrigger_input(pins[4]), .retrigger_strap_terminal,
    .exp_contact_loop_in, .exp_output_on, .expansion_feedback_out, .logic_setting, .exp_mode,
    .delay_setting_ms(17'h0000a)
  );
  relay_plant plant_u (
    .clock, .contactor_one, .contactor_two, .exp_output_on, .button(pins[5]), .weld(pins[6]),
    .expansion_feedback_out, .exp_contact_loop_in, .feedback_reset_loop
  );

  // ==========================================
  // Tasks
  task automatic chk(input logic [5:0] seen, input logic [5:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic step(input logic [6:0] v, input int n, input logic [5:0] want);
    @(posedge clock);
    pins <= v;
    repeat (n) @(posedge clock);
    #1;
    chk(outs, want);
  endtask : step

  task automatic boot(input logic [3:0] s, input exp_mode_e m, input logic r);
    @(posedge clock);
    rst_n <= 1'b0;
    pins <= 7'h20;
    logic_setting <= s;
    exp_mode <= m;
    retrigger_strap_terminal <= r;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (15) @(posedge clock);
  endtask : boot

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ==========================================
  // Test sequence
  initial begin
    boot(4'h6, MODE_IMMEDIATE, 1'b0);
    step(7'h21, 20, 6'h02);
    step(7'h23, 10, 6'h1c);
    step(7'h2b, 10, 6'h1d);
    step(7'h2a, 10, 6'h03);
    chk({5'h00, expansion_feedback_out}, 6'h00);
    step(7'h2b, 20, 6'h03);
    step(7'h23, 20, 6'h1c);
    step(7'h20, 10, 6'h02);
    step(7'h24, 10, 6'h1c);
    step(7'h20, 10, 6'h02);
    step(7'h60, 20, 6'h02);
    step(7'h63, 20, 6'h02);
    step(7'h23, 20, 6'h1c);
    step(7'h20, 10, 6'h02);
    $display("automatic logic test done");
    boot(4'h1, MODE_IMMEDIATE, 1'b0);
    chk({5'h00, expansion_feedback_out}, 6'h01);
    step(7'h01, 20, 6'h02);
    step(7'h21, 2000, 6'h02);
    step(7'h01, 20, 6'h02);
    step(7'h21, 6000, 6'h02);
    step(7'h01, 20, 6'h1c);
    step(7'h00, 10, 6'h02);
    $display("manual reset test done");
    for (int r = 0; r < 2; r++) begin
      boot(4'h6, MODE_OFF_DELAY, r[0]);
      retrigger_strap_terminal <= ~r[0];
      step(7'h28, 10, 6'h03);
      step(7'h20, 100, 6'h03);
      step(7'h28, 20, 6'h03);
      step(7'h20, 150, {5'h01, r[0]});
      step(7'h20, 150, 6'h02);
    end
    $display("off-delay test done");
    boot(4'h6, MODE_ON_DELAY, 1'b0);
    step(7'h28, 100, 6'h02);
    step(7'h28, 150, 6'h03);
    step(7'h20, 10, 6'h02);
    $display("on-delay test done");
    boot(4'h6, MODE_JOG, 1'b0);
    step(7'h28, 10, 6'h02);
    step(7'h38, 10, 6'h03);
    step(7'h28, 10, 6'h02);
    step(7'h38, 2000, 6'h02);
    step(7'h28, 9000, 6'h02);
    step(7'h38, 100, 6'h03);
    step(7'h38, 150, 6'h02);
    step(7'h20, 10, 6'h02);
    $display("jog test done");
    boot(4'h0, MODE_IMMEDIATE, 1'b0);
    step(7'h23, 20, 6'h22);
    $display("config fault test done");
    wrap_up();
  end
endmodule : test_safety_relay_logic_delay_expansion

bind safety_relay_top safety_relay_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .clock, .rst_n, .safety_input_a, .safety_input_b, .relay_link_in, .feedback_reset_loop,
  .contactor_one, .aux_off_status_out, .link_in_terminal, .jog_retrigger_input, .exp_output_on,
  .logic_setting, .exp_mode, .delay_setting_ms
);
`default_nettype wire
